/* hdl/stfm_pkg.sv */
package stfm_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_STATE = 8'h08;

    // Status register bit positions.
    localparam int ST_HIGH = 0;
    localparam int ST_LOW = 1;
    localparam int ST_UNDER = 2;
    localparam int ST_HOT = 3;
    localparam int ST_HEAT = 4;
    localparam int ST_POR = 5;
    localparam int ST_SUMMARY = 6;
    localparam int STATUS_W = 7;

    // Status after power-on: power-on and summary flags set.
    localparam logic [6:0] STATUS_POR = 7'h60;
    // Bits that sleep or a reset pulse never clear.
    localparam logic [6:0] STATUS_KEEP_POR = 7'h20;

    // Control register fields and reset value.
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_SLEEP = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // Fault output select codes; general fault is the default.
    localparam logic [1:0] SEL_GENERAL = 2'h0;
    localparam logic [1:0] SEL_STALL = 2'h1;
    localparam logic [1:0] SEL_SUPPLY = 2'h2;
    localparam logic [1:0] SEL_OPEN = 2'h3;

    // State register field positions.
    localparam int SR_DRIVE = 0;
    localparam int SR_PUMP_LOW = 1;
    localparam int SR_ARMED = 2;
    localparam int SR_SLEEP = 3;
    localparam int SR_SERIAL = 4;
    localparam int SR_FAULTS = 8;

    // Comparator indications, each high while its condition holds.
    typedef struct packed {
        logic ov;
        logic low;
        logic uv;
        logic pump_hi;
        logic pump_lo;
        logic tw;
        logic ot;
    } stfm_cmp_t;

    localparam int CMP_W = 7;
    localparam int SYNC_W = 8;

    // Power state of the block.
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b01,
        ST_SLEEP = 2'b10
    } stfm_state_t;

endpackage

/* hdl/stfm_sync.sv */
module stfm_sync (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [stfm_pkg::SYNC_W-1:0] din,
    output logic [stfm_pkg::SYNC_W-1:0] dout
);

    logic [stfm_pkg::SYNC_W-1:0] meta_q;

    // Two flip-flop chain; only the second stage is read outside.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end

endmodule

/* hdl/stfm_monitor.sv */
module stfm_monitor (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Comparator indications and reset pin.
    input wire stfm_pkg::stfm_cmp_t cmp_raw,
    input wire logic reset_input_low_n,
    // Drive control and fault pin.
    output logic drive_enable,
    output logic pump_threshold_low,
    output logic serial_enable,
    output logic sleep_active,
    output logic fault_pin_out,
    output logic fault_pin_oe_n
);

    stfm_pkg::stfm_cmp_t cmp_s;
    stfm_pkg::stfm_state_t state_q;
    logic rst_req_s;
    logic [1:0] fill_q;
    logic thr_low;
    logic [stfm_pkg::STATUS_W-1:0] status_q;
    logic [stfm_pkg::STATUS_W-1:0] status_set;
    logic [stfm_pkg::STATUS_W-1:0] status_clr;
    logic [2:0] ctrl_q;
    logic ff_by_por_q;
    logic armed_q;
    logic uv_hold_q;
    logic pump_uv;
    logic supply_fault;
    logic gen_fault;
    logic disable_drive;
    logic pin_low;
    logic sleep_req;
    logic setup_ph;
    logic done;
    logic rd_status;
    logic wr_ctrl;
    logic [31:0] rdata_d;
    logic rd_err;

    // Comparator and reset pin levels pass a two-stage chain.
    stfm_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({~reset_input_low_n, cmp_raw}),
        .dout({rst_req_s, cmp_s})
    );

    // Marks the chain as filled; its outputs mean nothing before that.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_q <= 2'h0;
        end else begin
            fill_q <= {fill_q[0], 1'b1};
        end
    end

    // Bus phases: ready is raised for the access cycle only.
    assign setup_ph = psel && !penable && !pready;
    assign done = psel && penable && pready;
    assign rd_status = done && !pwrite && paddr == stfm_pkg::ADDR_STATUS;
    assign wr_ctrl = done && pwrite && paddr == stfm_pkg::ADDR_CONTROL;

    // Live fault states; pump judged on the selected threshold.
    always_comb begin
        // Same-cycle threshold choice, so a supply dip cannot glitch it.
        thr_low = armed_q && cmp_s.low;
        pump_uv = thr_low ? cmp_s.pump_lo : cmp_s.pump_hi;
        supply_fault = cmp_s.ov || cmp_s.low || cmp_s.uv || uv_hold_q ||
            pump_uv;
        gen_fault = supply_fault || cmp_s.tw || cmp_s.ot;
        // Supply low and hot warning do not stop the drive.
        disable_drive = cmp_s.ov || cmp_s.uv || uv_hold_q || pump_uv ||
            cmp_s.ot || state_q != stfm_pkg::ST_ACTIVE ||
            !fill_q[1];
    end

    // Fault pin selection; stall and open-load live elsewhere.
    always_comb begin
        case (ctrl_q[stfm_pkg::CTRL_SEL_LSB +: 2])
            stfm_pkg::SEL_GENERAL: pin_low = gen_fault;
            stfm_pkg::SEL_SUPPLY: pin_low = supply_fault;
            default: pin_low = 1'b0;
        endcase
        if (state_q != stfm_pkg::ST_ACTIVE) begin
            pin_low = 1'b0;
        end
        // Pin stays low until the comparators are known.
        if (!fill_q[1]) begin
            pin_low = 1'b1;
        end
    end

    // Sticky flag sources; persisting faults re-set after a read.
    always_comb begin
        status_set = '0;
        status_set[stfm_pkg::ST_HIGH] = cmp_s.ov;
        status_set[stfm_pkg::ST_LOW] = cmp_s.low;
        status_set[stfm_pkg::ST_UNDER] = cmp_s.uv || pump_uv;
        status_set[stfm_pkg::ST_HOT] = cmp_s.tw;
        status_set[stfm_pkg::ST_HEAT] = cmp_s.ot;
        status_set[stfm_pkg::ST_SUMMARY] = gen_fault;
        if (state_q != stfm_pkg::ST_ACTIVE) begin
            status_set = '0;
        end
        // Only bits returned by the read are cleared.
        status_clr = rd_status ? prdata[stfm_pkg::STATUS_W-1:0] : '0;
        if (state_q == stfm_pkg::ST_SLEEP) begin
            status_clr = ~stfm_pkg::STATUS_KEEP_POR;
            status_clr[stfm_pkg::ST_SUMMARY] = !ff_by_por_q;
        end
    end

    // Register read mux; unmapped addresses answer with an error.
    always_comb begin
        rdata_d = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            stfm_pkg::ADDR_STATUS: begin
                rdata_d[stfm_pkg::STATUS_W-1:0] = status_q;
            end
            stfm_pkg::ADDR_CONTROL: begin
                rdata_d[2:0] = ctrl_q;
            end
            stfm_pkg::ADDR_STATE: begin
                rdata_d[stfm_pkg::SR_DRIVE] = drive_enable;
                rdata_d[stfm_pkg::SR_PUMP_LOW] = pump_threshold_low;
                rdata_d[stfm_pkg::SR_ARMED] = armed_q;
                rdata_d[stfm_pkg::SR_SLEEP] = sleep_active;
                rdata_d[stfm_pkg::SR_SERIAL] = serial_enable;
                rdata_d[stfm_pkg::SR_FAULTS +: stfm_pkg::CMP_W] = cmp_s;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    // Bus answer: data and error are captured in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_ph;
            if (setup_ph) begin
                prdata <= pwrite ? 32'h0000_0000 : rdata_d;
                pslverr <= rd_err;
            end else if (done) begin
                pslverr <= 1'b0;
            end
        end
    end

    // Control register: fault select and sleep request.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= stfm_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata[2:0];
        end
    end

    // Sleep is entered by the pin held low or the sleep bit.
    assign sleep_req = rst_req_s || ctrl_q[stfm_pkg::CTRL_SLEEP];

    // Power state machine.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= stfm_pkg::ST_ACTIVE;
        end else begin
            case (state_q)
                stfm_pkg::ST_ACTIVE: begin
                    if (sleep_req) begin
                        state_q <= stfm_pkg::ST_SLEEP;
                    end
                end
                stfm_pkg::ST_SLEEP: begin
                    if (!sleep_req) begin
                        state_q <= stfm_pkg::ST_ACTIVE;
                    end
                end
                default: state_q <= stfm_pkg::ST_ACTIVE;
            endcase
        end
    end

    // Status flags: set wins over every clear.
    // Hot and overheat flags outlive their fault states.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= stfm_pkg::STATUS_POR;
        end else begin
            status_q <= (status_q & ~status_clr) | status_set;
        end
    end

    // Remembers that the summary flag was set by power-on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ff_by_por_q <= 1'b1;
        end else if (status_clr[stfm_pkg::ST_SUMMARY]) begin
            ff_by_por_q <= 1'b0;
        end
    end

    // Threshold arming after power-on or wake.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_q <= 1'b0;
        end else if (state_q != stfm_pkg::ST_ACTIVE) begin
            armed_q <= 1'b0;
        end else if (!cmp_s.low && fill_q[1]) begin
            armed_q <= 1'b1;
        end
    end

    // Pump threshold follows supply low once armed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump_threshold_low <= 1'b0;
        end else begin
            pump_threshold_low <= thr_low;
        end
    end

    // Undervoltage recovery waits for supply low and pump.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_hold_q <= 1'b0;
        end else if (cmp_s.uv) begin
            uv_hold_q <= 1'b1;
        end else if (!cmp_s.low && !pump_uv) begin
            uv_hold_q <= 1'b0;
        end
    end

    // Drive enable and serial port; control register stays intact, sleep clears the status flags other than those set by power-on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_enable <= 1'b0;
            serial_enable <= 1'b0;
            sleep_active <= 1'b0;
        end else begin
            drive_enable <= !disable_drive;
            serial_enable <= !cmp_s.uv && state_q == stfm_pkg::ST_ACTIVE;
            sleep_active <= state_q == stfm_pkg::ST_SLEEP;
        end
    end

    // Open-drain fault pin, pulled low during reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_pin_out <= 1'b0;
            fault_pin_oe_n <= 1'b0;
        end else begin
            fault_pin_out <= 1'b0;
            fault_pin_oe_n <= !pin_low;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ov_drive_off: assert property (cmp_s.ov |=> !drive_enable)
        else $error("overvoltage did not disable drive");
    a_ov_flag_set: assert property (
        cmp_s.ov && state_q == stfm_pkg::ST_ACTIVE
        |=> status_q[stfm_pkg::ST_HIGH])
        else $error("high supply flag not set");
    a_low_keeps_drive: assert property (
        cmp_s.low && !disable_drive |=> drive_enable)
        else $error("supply low stopped the drive");
    a_thr_follow_low: assert property (
        armed_q && cmp_s.low |=> pump_threshold_low)
        else $error("pump threshold not lowered");
    a_thr_high_start: assert property (
        !armed_q && !$past(armed_q) |-> !pump_threshold_low)
        else $error("pump threshold low before arming");
    a_uv_hold_wait: assert property (
        uv_hold_q && cmp_s.low |=> !drive_enable [*2])
        else $error("drive enabled before recovery");
    a_flags_sticky: assert property (
        status_clr == '0 |=> (status_q & $past(status_q))
        == $past(status_q))
        else $error("status flag dropped without clear");
    a_read_reset: assert property (
        rd_status && cmp_s.ot && state_q == stfm_pkg::ST_ACTIVE
        |=> status_q[stfm_pkg::ST_HEAT])
        else $error("persisting overheat flag lost on read");
    a_general_pin: assert property (
        ctrl_q[1:0] == stfm_pkg::SEL_GENERAL && gen_fault &&
        state_q == stfm_pkg::ST_ACTIVE |=> !fault_pin_oe_n)
        else $error("general fault pin not pulled low");
    a_bus_answer: assert property (
        setup_ph |=> pready ##1 !pready)
        else $error("bus answer not one access cycle");

    c_ov_recover: cover property (cmp_s.ov ##[1:20] drive_enable);
    c_read_clear: cover property (rd_status && status_q != '0);
    c_sleep_wake: cover property (
        state_q == stfm_pkg::ST_SLEEP ##1 state_q == stfm_pkg::ST_ACTIVE);

endmodule

/* verif/stfm_host_model.sv */
module stfm_host_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Open-drain fault pin and power state of the device.
    input wire logic fault_pin_out,
    input wire logic fault_pin_oe_n,
    input wire logic sleep_active,
    // Resolved pin level and the host's own step hold.
    output logic fault_line,
    output logic step_hold
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] settle_q;

    // The board pull-up holds the line high whenever the device lets go.
    assign fault_line = fault_pin_oe_n ? 1'b1 : fault_pin_out;

    // Settling count restarts at power-up and on every sleep.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_q <= 4'hF;
        end else if (sleep_active) begin
            settle_q <= 4'hF;
        end else if (settle_q != 4'h0) begin
            settle_q <= settle_q - 4'h1;
        end
    end

    // No steps while the device settles or reports a fault.
    assign step_hold = (settle_q != 4'h0) || !fault_line;
endmodule

/* verif/tb_stfm_monitor.sv */
module tb_stfm_monitor;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic reset_input_low_n, drive_enable, pump_threshold_low;
    logic serial_enable, sleep_active, fault_pin_out, fault_pin_oe_n;
    logic fault_line, step_hold;
    stfm_pkg::stfm_cmp_t cmp_raw;
    int fails, compares, seed;
    // Expected behaviour per comparator pattern: status, drive, low pump.
    logic [6:0] tc[8] = '{7'h40, 7'h20, 7'h10, 7'h08,
                          7'h2C, 7'h28, 7'h02, 7'h01};
    logic [6:0] ts[8] = '{7'h41, 7'h42, 7'h44, 7'h44,
                          7'h46, 7'h42, 7'h48, 7'h50};
    logic [7:0] td = 8'h62;
    logic [7:0] tl = 8'h32;

    stfm_monitor stfm_monitor_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_raw(cmp_raw),
        .reset_input_low_n(reset_input_low_n),
        .drive_enable(drive_enable),
        .pump_threshold_low(pump_threshold_low),
        .serial_enable(serial_enable), .sleep_active(sleep_active),
        .fault_pin_out(fault_pin_out), .fault_pin_oe_n(fault_pin_oe_n));

    stfm_host_model stfm_host_model_inst (.pclk(pclk), .presetn(presetn),
        .fault_pin_out(fault_pin_out), .fault_pin_oe_n(fault_pin_oe_n),
        .sleep_active(sleep_active), .fault_line(fault_line),
        .step_hold(step_hold));

    // Free-running clock.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Prints the counts and the verdict, then stops.
    task automatic test_done();
        $display("Compares %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Counts one comparison and reports a mismatch.
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask

    // One APB transfer; a read compares data, both compare the error.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] e,
                       input logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            test_done();
        end
        if (!w) chk("prdata", e, prdata);
        chk("pslverr", 32'(err), 32'(pslverr));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Status read, which also clears what it returns.
    task automatic rs(input logic [31:0] e);
        apb(1'b0, stfm_pkg::ADDR_STATUS, 32'h0, e, 1'b0);
    endtask

    // Control write.
    task automatic wc(input logic [31:0] d);
        apb(1'b1, stfm_pkg::ADDR_CONTROL, d, 32'h0, 1'b0);
    endtask

    // Waits a number of clock edges.
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    // Main sequence.
    initial begin
        seed = 70271;
        fails = 0;
        compares = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cmp_raw = '0;
        reset_input_low_n = 1'b1;
        cyc(10);
        presetn <= 1'b1;
        cyc(8);
        rs(32'h60);
        rs(32'h0);
        apb(1'b1, stfm_pkg::ADDR_STATUS, $random(seed), 32'h0, 1'b0);
        rs(32'h0);
        apb(1'b0, stfm_pkg::ADDR_CONTROL, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h0C, 32'h0, 32'h0, 1'b1);
        chk("hold", 32'h0, 32'(step_hold));
        for (int i = 0; i < 8; i++) begin
            cmp_raw <= tc[i];
            cyc(4 + ($random(seed) & 3));
            chk("drive", 32'(td[i]), 32'(drive_enable));
            chk("line", 32'h0, 32'(fault_line));
            chk("pump", 32'(tl[i]), 32'(pump_threshold_low));
            chk("serial", 32'(!tc[i][4]), 32'(serial_enable));
            rs(32'(ts[i]));
            rs(32'(ts[i]));
            cmp_raw <= '0;
            cyc(5);
            chk("drive", 32'h1, 32'(drive_enable));
            chk("line", 32'h1, 32'(fault_line));
            chk("pump", 32'h0, 32'(pump_threshold_low));
            rs(32'(ts[i]));
            rs(32'h0);
        end
        cmp_raw <= 7'h30;
        cyc(5);
        cmp_raw <= 7'h20;
        cyc(5);
        chk("drive", 32'h0, 32'(drive_enable));
        cmp_raw <= '0;
        cyc(5);
        chk("drive", 32'h1, 32'(drive_enable));
        rs(32'h46);
        rs(32'h0);
        for (int s = 0; s < 4; s++) begin
            wc(32'(s));
            apb(1'b0, stfm_pkg::ADDR_CONTROL, 32'h0, 32'(s), 1'b0);
            for (int f = 0; f < 2; f++) begin
                cmp_raw <= (f == 1) ? 7'h02 : 7'h40;
                cyc(5);
                chk("line", 32'(!(s == 0 || (s == 2 && f == 0))), 32'(fault_line));
                cmp_raw <= '0;
                cyc(5);
            end
        end
        wc(32'h0);
        rs(32'h49);
        cmp_raw <= 7'h40;
        cyc(5);
        cmp_raw <= '0;
        wc(32'h4);
        cyc(4);
        chk("sleep", 32'h1, 32'(sleep_active));
        chk("drive", 32'h0, 32'(drive_enable));
        wc(32'h0);
        cyc(6);
        rs(32'h0);
        cmp_raw <= 7'h02;
        cyc(5);
        cmp_raw <= '0;
        reset_input_low_n <= 1'b0;
        cyc(6);
        chk("sleep", 32'h1, 32'(sleep_active));
        chk("line", 32'h1, 32'(fault_line));
        reset_input_low_n <= 1'b1;
        cyc(6);
        rs(32'h0);
        cmp_raw <= 7'h20;
        presetn <= 1'b0;
        cyc(2);
        chk("drive", 32'h0, 32'(drive_enable));
        chk("line", 32'h0, 32'(fault_line));
        presetn <= 1'b1;
        cyc(8);
        chk("pump", 32'h0, 32'(pump_threshold_low));
        cmp_raw <= '0;
        cyc(5);
        cmp_raw <= 7'h20;
        cyc(5);
        chk("pump", 32'h1, 32'(pump_threshold_low));
        test_done();
    end
endmodule
